// >>> hw/nv_option_defs.svh
`ifndef NV_OPTION_DEFS_SVH
`define NV_OPTION_DEFS_SVH
// ************************************************************
// high-page map (register indices; apb byte address is four times the index)
// ************************************************************
`define HIGH_PAGE_BASE 16'h1800
`define OFS_FLASH_CLOCK_DIVIDER 16'h1820
`define OFS_FLASH_OPTION_WORKING 16'h1821
`define OFS_FLASH_CONFIGURATION 16'h1823
`define OFS_FLASH_PROTECTION_WORKING 16'h1824
`define OFS_FLASH_STATUS 16'h1825
`define OFS_FLASH_COMMAND 16'h1826
`define OFS_KEY_ENTRY_LO 16'h1828
`define OFS_KEY_ENTRY_HI 16'h1829
`define OFS_SECURITY_STATUS 16'h182A
`define OFS_OSC_TRIM 16'h182B
`define OFS_OSC_STATUS_CONTROL 16'h182C
// ************************************************************
// nonvolatile locations
// ************************************************************
`define NV_FINE_TRIM 16'hFFAE
`define NV_OSC_TRIM 16'hFFAF
`define NV_KEY_FIRST 16'hFFB0
`define NV_KEY_LAST 16'hFFB7
`define NV_PROTECTION 16'hFFBD
`define NV_OPTION 16'hFFBF
// ************************************************************
// fields and values
// ************************************************************
`define KEY_ENABLE_BIT 7
`define SECURITY_UNSECURED 2'h2
`define KEY_ACCESS_BIT 5
`define RESET_STACK_POINTER 16'h00FF
`define DIRECT_PAGE_LIMIT 16'h0100
`define FLASH_PAGE_BYTES 512
`define FLASH_LAST_ADDR 16'hFFFF
`define FLASH_BYTES_LARGE 8192
`define FLASH_BYTES_SMALL 4096
`define IDLE_READS_FOR_SLEEP 4
`endif

// >>> hw/nv_option_pkg.sv
package nv_option_pkg;
  typedef struct packed {
    logic key_enable_bit;
    logic vector_redirect_disable;
    logic [3:0] zero;
    logic [1:0] security_field;
  } option_type;
  typedef struct packed {
    logic [6:0] protect_boundary_field;
    logic protect_disable_bit;
  } protection_type;
  typedef struct packed {
    logic req;
    logic write;
    logic from_debug;
    logic from_secure_code;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ram_req_type;
  typedef enum logic [1:0] {
    load_prot = 2'h0,
    load_opt = 2'h1,
    load_trim = 2'h3,
    load_done = 2'h2
  } load_state_type;
endpackage

// >>> hw/nv_option_security_loader.sv
// Contract
// - high-page control block based at 0x1800
// - reset copies stored protection/option to working
// - reset loads factory trim into oscillator registers
// - eight-byte backdoor key held in nonvolatile
// - key match unsecures only when key enabled
// - key entry only from secure user code
// - key disabled: only blank mass erase unsecures
// - security field 1:0 means unsecured
// - RAM untouched by reset
// - reset stack pointer value is 0x00FF
// - secured: block debug and non-secure RAM access
// - RAM below 0x0100 is direct-page reachable
// - flash is 512-byte pages, 16 or 8
// - flash powers down between slow reads
// - protected region from 512 boundary to 0xFFFF
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "nv_option_defs.svh"
module nv_option_security_loader #(
  parameter int FLASH_BYTES = `FLASH_BYTES_LARGE,
  parameter int RAM_BYTES = 512
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [15:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error
  input wire logic pdebug, // access comes from background debug
  input wire logic psecure_code, // cpu executes from secure memory
  input wire logic [7:0] nv_protection_in, // stored protection byte
  input wire logic [7:0] nv_option_in, // stored option byte
  input wire logic [63:0] nv_key_in, // backdoor comparison key
  input wire logic [8:0] factory_trim_in, // information row trim
  input wire logic mass_erase_blank, // erase verified blank
  input wire logic [15:0] flash_read_addr, // flash read address
  input wire logic flash_read, // flash read strobe
  input wire nv_option_pkg::ram_req_type ram_req, // ram request
  output logic [7:0] ram_rdata, // ram read data
  output logic ram_blocked, // ram access refused
  output logic direct_page, // ram address is direct-page
  output logic secured, // device is secured
  output logic [15:0] reset_sp, // stack pointer after reset
  output logic [15:0] protect_start, // protected region start
  output logic protect_hit, // read address in protected region
  output logic [4:0] flash_pages, // page count
  output logic flash_sleep, // flash array powered down
  output logic loader_done // working copies valid
);
  nv_option_pkg::load_state_type load_state;
  nv_option_pkg::option_type option_working;
  nv_option_pkg::protection_type protection_working;
  logic [7:0] clock_divider;
  logic [7:0] flash_config;
  logic [7:0] flash_stat;
  logic [7:0] flash_cmd;
  logic [7:0] osc_trim;
  logic [7:0] osc_status;
  logic [63:0] key_entry;
  logic key_unlock;
  logic erase_unlock;
  logic [2:0] idle_count;
  logic [7:0] ram_mem [RAM_BYTES];
  logic wr_en;
  logic rd_en;
  logic key_path_open;

  // each register takes one aligned apb word: byte address is four times the index
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == {ofs[13:0], 2'b00});
  endfunction

  // ************************************************************
  // reset-time loading
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_state <= nv_option_pkg::load_prot;
    end else begin
      case (load_state)
        nv_option_pkg::load_prot: load_state <= nv_option_pkg::load_opt;
        nv_option_pkg::load_opt: load_state <= nv_option_pkg::load_trim;
        nv_option_pkg::load_trim: load_state <= nv_option_pkg::load_done;
        default: load_state <= nv_option_pkg::load_done;
      endcase
    end
  end

  assign loader_done = (load_state == nv_option_pkg::load_done);
  assign wr_en = psel && penable && pwrite && loader_done;
  assign rd_en = psel && penable && !pwrite;
  assign reset_sp = `RESET_STACK_POINTER;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protection_working <= '0;
    end else if (load_state == nv_option_pkg::load_prot) begin
      protection_working <= nv_protection_in;
    end else if (wr_en && hit(paddr, `OFS_FLASH_PROTECTION_WORKING)) begin
      // only further protection may be added by software
      protection_working <= protection_working & pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_working <= '0;
    end else if (load_state == nv_option_pkg::load_opt) begin
      option_working <= {nv_option_in[7:6], 4'h0, nv_option_in[1:0]};
    end
  end

  // user trims in flash are not applied by hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_trim <= 8'h80;
      osc_status <= 8'h00;
    end else if (load_state == nv_option_pkg::load_trim) begin
      osc_trim <= factory_trim_in[8:1];
      osc_status <= {7'h00, factory_trim_in[0]};
    end else if (wr_en && hit(paddr, `OFS_OSC_TRIM)) begin
      osc_trim <= pwdata[7:0];
    end else if (wr_en && hit(paddr, `OFS_OSC_STATUS_CONTROL)) begin
      osc_status <= {7'h00, pwdata[0]};
    end
  end

  // ************************************************************
  // flash control registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_divider <= 8'h00;
      flash_config <= 8'h00;
      flash_cmd <= 8'h00;
    end else if (wr_en) begin
      if (hit(paddr, `OFS_FLASH_CLOCK_DIVIDER) && !clock_divider[7]) begin
        clock_divider <= {1'b1, pwdata[6:0]};
      end else if (hit(paddr, `OFS_FLASH_CONFIGURATION)) begin
        flash_config <= {2'h0, pwdata[`KEY_ACCESS_BIT], 5'h00};
      end else if (hit(paddr, `OFS_FLASH_COMMAND)) begin
        flash_cmd <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_stat <= 8'hC0;
    end else if (wr_en && hit(paddr, `OFS_FLASH_STATUS)) begin
      flash_stat <= flash_stat & ~{2'h0, pwdata[5:4], 4'h0};
    end
  end

  // ************************************************************
  // security and backdoor key
  // ************************************************************
  // key path: enabled option, key access set, secure non-debug code
  assign key_path_open = option_working.key_enable_bit
    && flash_config[`KEY_ACCESS_BIT] && psecure_code && !pdebug;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_entry <= '0;
    end else if (wr_en && key_path_open) begin
      if (hit(paddr, `OFS_KEY_ENTRY_LO)) begin
        key_entry[31:0] <= pwdata;
      end else if (hit(paddr, `OFS_KEY_ENTRY_HI)) begin
        key_entry[63:32] <= pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_unlock <= 1'b0;
    end else if (wr_en && key_path_open && hit(paddr, `OFS_KEY_ENTRY_HI)) begin
      key_unlock <= ({pwdata, key_entry[31:0]} == nv_key_in);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_unlock <= 1'b0;
    end else if (mass_erase_blank && loader_done) begin
      erase_unlock <= 1'b1;
    end
  end

  assign secured = !loader_done
    || ((option_working.security_field != `SECURITY_UNSECURED)
    && !key_unlock && !erase_unlock);

  // ************************************************************
  // ram with security gate
  // ************************************************************
  assign ram_blocked = ram_req.req && secured
    && (ram_req.from_debug || !ram_req.from_secure_code);
  assign direct_page = ram_req.addr < `DIRECT_PAGE_LIMIT;

  // ram has no reset term so contents survive reset
  always_ff @(posedge pclk) begin
    if (ram_req.req && ram_req.write && !ram_blocked
        && ram_req.addr < 16'(RAM_BYTES)) begin
      ram_mem[ram_req.addr[$clog2(RAM_BYTES)-1:0]] <= ram_req.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_rdata <= 8'h00;
    end else if (ram_req.req && !ram_req.write && !ram_blocked
                 && ram_req.addr < 16'(RAM_BYTES)) begin
      ram_rdata <= ram_mem[ram_req.addr[$clog2(RAM_BYTES)-1:0]];
    end else begin
      ram_rdata <= 8'h00;
    end
  end

  // ************************************************************
  // flash geometry, protection and power-down
  // ************************************************************
  assign flash_pages = 5'(FLASH_BYTES / `FLASH_PAGE_BYTES);
  assign protect_start = {protection_working.protect_boundary_field, 9'h000};
  assign protect_hit = !protection_working.protect_disable_bit
    && (flash_read_addr >= protect_start);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_count <= 3'h0;
    end else if (flash_read) begin
      idle_count <= 3'h0;
    end else if (idle_count != 3'(`IDLE_READS_FOR_SLEEP)) begin
      idle_count <= idle_count + 3'h1;
    end
  end
  assign flash_sleep = (idle_count == 3'(`IDLE_READS_FOR_SLEEP));

  // ************************************************************
  // apb slave
  // ************************************************************
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
    end
  end

  logic in_block;
  // index page 0x18xx lands at byte addresses 0x6000 to 0x63FF
  assign in_block = (paddr[15:10] == 6'(`HIGH_PAGE_BASE >> 8));
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (!in_block) begin
      next_prdata = 32'h0000_0000;
    end else if (hit(paddr, `OFS_FLASH_CLOCK_DIVIDER)) begin
      next_prdata = {24'h0, clock_divider};
    end else if (hit(paddr, `OFS_FLASH_OPTION_WORKING)) begin
      next_prdata = {24'h0, option_working};
    end else if (hit(paddr, `OFS_FLASH_CONFIGURATION)) begin
      next_prdata = {24'h0, flash_config};
    end else if (hit(paddr, `OFS_FLASH_PROTECTION_WORKING)) begin
      next_prdata = {24'h0, protection_working};
    end else if (hit(paddr, `OFS_FLASH_STATUS)) begin
      next_prdata = {24'h0, flash_stat};
    end else if (hit(paddr, `OFS_FLASH_COMMAND)) begin
      next_prdata = {24'h0, flash_cmd};
    end else if (hit(paddr, `OFS_SECURITY_STATUS)) begin
      next_prdata = {29'h0, erase_unlock, key_unlock, secured};
    end else if (hit(paddr, `OFS_OSC_TRIM)) begin
      next_prdata = {24'h0, osc_trim};
    end else if (hit(paddr, `OFS_OSC_STATUS_CONTROL)) begin
      next_prdata = {24'h0, osc_status};
    end
  end
  assign prdata = rd_en ? next_prdata : 32'h0000_0000;

  // ************************************************************
  // checks
  // ************************************************************
  a_load_option: assert property (@(posedge pclk) disable iff (!presetn)
    load_state == nv_option_pkg::load_opt |=>
      option_working.security_field == $past(nv_option_in[1:0]))
    else $error("option byte not copied");
  // sampled presetn skips the release edge, where the flops still ran their reset branch
  a_load_prot: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && load_state == nv_option_pkg::load_prot
      |=> protection_working == $past(nv_protection_in))
    else $error("protection byte not copied");
  a_load_trim: assert property (@(posedge pclk) disable iff (!presetn)
    load_state == nv_option_pkg::load_trim |=> osc_trim == $past(factory_trim_in[8:1]))
    else $error("factory trim not loaded");
  a_key_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !option_working.key_enable_bit && !key_unlock |=> !key_unlock)
    else $error("key unlocked while disabled");
  a_debug_key: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && pdebug && !key_unlock |=> !key_unlock)
    else $error("key accepted from debug");
  a_secure_field: assert property (@(posedge pclk) disable iff (!presetn)
    loader_done && option_working.security_field == 2'h2 |-> !secured)
    else $error("unsecured field still secured");
  a_ram_block: assert property (@(posedge pclk) disable iff (!presetn)
    ram_req.req && secured && ram_req.from_debug |-> ram_blocked)
    else $error("debug ram access not blocked");
  a_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn)
    flash_read |=> !flash_sleep [*4])
    else $error("flash slept too early");
  a_stack_reset: assert property (@(posedge pclk) disable iff (!presetn)
    reset_sp == 16'h00FF)
    else $error("reset stack pointer wrong");

  // ************************************************************
  // loader, key, erase, ram gate, flash and apb read checks
  // ************************************************************
  a_load_order: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && load_state == nv_option_pkg::load_prot
      |=> load_state == nv_option_pkg::load_opt)
    else $error("loader skipped the option step");
  a_config_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !loader_done |=> $stable(flash_config))
    else $error("register written before loading ended");
  a_trim_fine: assert property (@(posedge pclk) disable iff (!presetn)
    load_state == nv_option_pkg::load_trim
      |=> osc_status[0] == $past(factory_trim_in[0]))
    else $error("factory fine trim not loaded");
  a_key_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(key_unlock) |-> $past(option_working.key_enable_bit))
    else $error("key unlocked without key enable");
  a_key_secure_code: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && !psecure_code && !key_unlock
      |=> !key_unlock)
    else $error("key accepted from non-secure code");
  a_erase_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    erase_unlock |=> erase_unlock)
    else $error("erase unlock dropped");
  a_ram_nonsecure: assert property (@(posedge pclk) disable iff (!presetn)
    ram_req.req && secured && !ram_req.from_secure_code
      |-> ram_blocked)
    else $error("non-secure ram access not blocked");
  a_ram_open: assert property (@(posedge pclk) disable iff (!presetn)
    ram_req.req && !secured |-> !ram_blocked)
    else $error("ram blocked while unsecured");
  a_direct_low: assert property (@(posedge pclk) disable iff (!presetn)
    ram_req.addr[15:8] == 8'h00 |-> direct_page)
    else $error("low ram not direct-page");
  a_pages_geom: assert property (@(posedge pclk) disable iff (!presetn)
    32'(flash_pages) * `FLASH_PAGE_BYTES == FLASH_BYTES)
    else $error("page count does not cover flash");
  a_sleep_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (presetn && !flash_read) [*4]
      |=> flash_sleep)
    else $error("flash awake after idle cycles");
  a_protect_top: assert property (@(posedge pclk) disable iff (!presetn)
    !protection_working.protect_disable_bit && flash_read_addr == `FLASH_LAST_ADDR
      |-> protect_hit)
    else $error("last flash address not protected");
  a_protect_align: assert property (@(posedge pclk) disable iff (!presetn)
    protect_start[8:0] == 9'h000)
    else $error("protect start off a page boundary");
  a_protect_off: assert property (@(posedge pclk) disable iff (!presetn)
    protection_working.protect_disable_bit |-> !protect_hit)
    else $error("protection hit while disabled");
  a_option_stable: assert property (@(posedge pclk) disable iff (!presetn)
    loader_done
      |=> $stable(option_working))
    else $error("working option changed after loading");
  a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && !in_block
      |-> prdata == 32'h0000_0000)
    else $error("read outside block not zero");
endmodule // nv_option_security_loader
`default_nettype wire

// >>> testbench/nv_image_model.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// nonvolatile image seen by the loader
// ************************************************************
module nv_image_model #(
  parameter logic [63:0] KEY = 64'h1122334455667788, // arbitrary key value
  parameter logic [8:0] FACTORY_TRIM = 9'h15B // arbitrary trim value
) (
  input wire logic [1:0] image, // image select
  output logic [7:0] nv_prot, // stored protection byte
  output logic [7:0] nv_opt, // stored option byte
  output logic [63:0] nv_key, // backdoor comparison key
  output logic [8:0] trim, // information row trim
  output logic [7:0] user_trim // user trim, never applied by hardware
);
  assign nv_key = KEY;
  assign trim = FACTORY_TRIM;
  assign user_trim = 8'h3C;
  always_comb begin
    case (image)
      2'h0: begin
        nv_prot = 8'hA4;
        nv_opt = 8'h83;
      end
      2'h1: begin
        nv_prot = 8'hFF;
        nv_opt = 8'h01;
      end
      default: begin
        nv_prot = 8'h7E;
        nv_opt = 8'h02;
      end
    endcase
  end
endmodule // nv_image_model
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "nv_option_defs.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, pdebug = 1'b0, psecure_code = 1'b0;
  logic [1:0] image = 2'h0;
  logic [7:0] nv_prot, nv_opt, user_trim, ram_rdata;
  logic [63:0] nv_key;
  logic [8:0] trim;
  logic mass_erase_blank = 1'b0, flash_read = 1'b0;
  logic [15:0] flash_read_addr = 16'h0000, reset_sp, protect_start;
  nv_option_pkg::ram_req_type ram_req = '0;
  logic ram_blocked, direct_page, secured, protect_hit, flash_sleep, loader_done;
  logic [4:0] flash_pages;
  int n_fail = 0;
  int n_checks = 0;
  always #4 pclk = ~pclk;
  nv_image_model i_nv_image_model (.image(image), .nv_prot(nv_prot), .nv_opt(nv_opt),
    .nv_key(nv_key), .trim(trim), .user_trim(user_trim));
  nv_option_security_loader i_nv_option_security_loader (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .pdebug(pdebug),
    .psecure_code(psecure_code), .nv_protection_in(nv_prot), .nv_option_in(nv_opt),
    .nv_key_in(nv_key), .factory_trim_in(trim), .mass_erase_blank(mass_erase_blank),
    .flash_read_addr(flash_read_addr), .flash_read(flash_read), .ram_req(ram_req),
    .ram_rdata(ram_rdata), .ram_blocked(ram_blocked), .direct_page(direct_page),
    .secured(secured), .reset_sp(reset_sp), .protect_start(protect_start),
    .protect_hit(protect_hit), .flash_pages(flash_pages), .flash_sleep(flash_sleep),
    .loader_done(loader_done));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    // checks after a tick see the values that stood just before that edge
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {a[13:0], 2'b00}; // byte address is four times the register index
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset(input logic [1:0] img);
    int i;
    image <= img;
    presetn <= 1'b0;
    tick(5);
    chk("secured in reset", secured, 1'b1);
    presetn <= 1'b1;
    for (i = 0; i < 50 && loader_done !== 1'b1; i++) tick(1);
    chk("loader_done", loader_done, 1'b1);
  endtask
  task automatic key_entry();
    apb(1'b1, `OFS_FLASH_CONFIGURATION, 32'h20);
    apb(1'b1, `OFS_KEY_ENTRY_LO, nv_key[31:0]);
    apb(1'b1, `OFS_KEY_ENTRY_HI, nv_key[63:32]);
    tick(1);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    close_out();
  end
  initial begin
    do_reset(2'h0);
    apb(1'b0, `OFS_FLASH_OPTION_WORKING, 0); chk("option", q, 32'h83);
    apb(1'b0, `OFS_FLASH_PROTECTION_WORKING, 0); chk("prot", q, 32'hA4);
    apb(1'b0, `OFS_OSC_TRIM, 0); chk("trim", q, {24'h0, trim[8:1]});
    apb(1'b0, `OFS_OSC_STATUS_CONTROL, 0); chk("fine", q[0], trim[0]);
    apb(1'b1, `OFS_OSC_TRIM, {24'h0, user_trim});
    apb(1'b0, `OFS_OSC_TRIM, 0); chk("user trim", q, {24'h0, user_trim});
    apb(1'b0, 16'h1822, 0); chk("unmapped", q, 32'h0);
    chk("no error", pslverr, 1'b0);
    apb(1'b0, `OFS_FLASH_STATUS, 0); chk("status", q, 32'hC0);
    apb(1'b1, `OFS_FLASH_CLOCK_DIVIDER, 32'h13);
    apb(1'b1, `OFS_FLASH_CLOCK_DIVIDER, 32'h05);
    apb(1'b0, `OFS_FLASH_CLOCK_DIVIDER, 0); chk("divider once", q, 32'h93);
    apb(1'b1, `OFS_FLASH_COMMAND, 32'h41);
    apb(1'b0, `OFS_FLASH_COMMAND, 0); chk("command", q, 32'h41);
    chk("sp", reset_sp, 16'h00FF);
    chk("pages", flash_pages, 5'h10);
    chk("pstart", protect_start, 16'hA400);
    flash_read_addr <= 16'hFFFF;
    flash_read <= 1'b1;
    tick(1);
    chk("hit top", protect_hit, 1'b1);
    flash_read <= 1'b0;
    flash_read_addr <= 16'hA3FF;
    tick(1);
    chk("hit below", protect_hit, 1'b0);
    chk("awake", flash_sleep, 1'b0);
    tick(8);
    chk("asleep", flash_sleep, 1'b1);
    $display("test load done");
    ram_req <= '{req: 1'b1, write: 1'b0, from_debug: 1'b1, from_secure_code: 1'b0,
      addr: 16'h00FF, wdata: 8'h00};
    tick(1);
    chk("ram dbg", ram_blocked, 1'b1);
    chk("direct", direct_page, 1'b1);
    ram_req.from_debug <= 1'b0;
    ram_req.addr <= 16'h0100;
    tick(1);
    chk("ram nonsec", ram_blocked, 1'b1);
    chk("not direct", direct_page, 1'b0);
    ram_req <= '0;
    pdebug <= 1'b1;
    psecure_code <= 1'b1;
    key_entry();
    chk("debug key", secured, 1'b1);
    pdebug <= 1'b0;
    key_entry();
    chk("key match", secured, 1'b0);
    apb(1'b0, `OFS_SECURITY_STATUS, 0); chk("sec stat", q[2:0], 3'h2);
    ram_req <= '{req: 1'b1, write: 1'b1, from_debug: 1'b1, from_secure_code: 1'b0,
      addr: 16'h0080, wdata: 8'h5A};
    tick(1);
    chk("ram open", ram_blocked, 1'b0);
    ram_req <= '0;
    $display("test key done");
    do_reset(2'h1);
    chk("relocked", secured, 1'b1);
    key_entry();
    chk("key off", secured, 1'b1);
    ram_req <= '{req: 1'b1, write: 1'b0, from_debug: 1'b0, from_secure_code: 1'b1,
      addr: 16'h0080, wdata: 8'h00};
    tick(2);
    chk("ram kept", ram_rdata, 8'h5A);
    ram_req <= '0;
    mass_erase_blank <= 1'b1;
    tick(2);
    chk("erase unlock", secured, 1'b0);
    mass_erase_blank <= 1'b0;
    $display("test erase done");
    do_reset(2'h2);
    chk("unsecured", secured, 1'b0);
    image <= 2'h0;
    tick(3);
    chk("working copy", secured, 1'b0);
    $display("test option done");
    close_out();
  end
endmodule // tb
`default_nettype wire
